// File: verilog/adc_ctrl_pkg.sv
// Purpose: Shared constants for the converter sequencer control block
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: Offsets are byte addresses on the plain register port
package adc_ctrl_pkg;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h20;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h21;
  localparam logic [7:0] ADDR_CONTROL = 8'h22;
  localparam logic [7:0] ADDR_CLOCK_SETTING = 8'h23;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h25;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h26;
  localparam int CHANNELS = 8;
  localparam int RESULT_BITS = 12;
  localparam int CH_LSB = 0;
  localparam int CFG_LSB = 3;
  localparam int PEND_BIT = 6;
  localparam int START_BIT = 7;
  localparam int TEST_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV8 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [2:0] CFG_ALL = 3'h7;
  // One sample tick plus one converter clock per result bit
  localparam logic [3:0] CONV_TICKS = 4'hd;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage : adc_ctrl_pkg

// File: verilog/conv_clk_div.sv
// Purpose: Converter clock enable divider
// Assumes: Single system clock
// Notes: Select 11 is undefined; it is treated as divide by 32
`timescale 1ns/100ps
module conv_clk_div
  import adc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [1:0] i_sel,
  output logic o_tick
);
  typedef struct packed {
    logic [4:0] count;
    logic tick;
  } div_state_t;
  div_state_t cur;
  div_state_t next_cur;
  logic [4:0] last;
  // Terminal count for the chosen divider
  always_comb begin
    case (i_sel)
      CLK_SEL_DIV2: last = DIV2_LAST;
      CLK_SEL_DIV8: last = DIV8_LAST;
      default: last = DIV32_LAST;
    endcase
  end
  // Count and emit a one-cycle enable
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (!i_run) begin
      next_cur.count = 5'h00;
    end else if (cur.count >= last) begin
      next_cur.count = 5'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + 5'h01;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign o_tick = cur.tick;
endmodule : conv_clk_div

// File: verilog/sample_sync.sv
// Purpose: Three-stage synchroniser for the analog core result
// Assumes: Inputs come from the converter core, outside the clock domain
// Notes: A change counts once the second and third stages agree
`timescale 1ns/100ps
module sample_sync
  import adc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [RESULT_BITS-1:0] i_async,
  output logic [RESULT_BITS-1:0] o_sync
);
  typedef struct packed {
    logic [RESULT_BITS-1:0] s1;
    logic [RESULT_BITS-1:0] s2;
    logic [RESULT_BITS-1:0] s3;
    logic [RESULT_BITS-1:0] held;
  } sync_state_t;
  sync_state_t cur;
  sync_state_t next_cur;
  // Shift the chain; accept only agreeing bits
  always_comb begin
    next_cur = cur;
    next_cur.s1 = i_async;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    for (int b = 0; b < RESULT_BITS; b++) begin
      if (cur.s2[b] == cur.s3[b]) begin
        next_cur.held[b] = cur.s3[b];
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign o_sync = cur.held;
endmodule : sample_sync

// File: verilog/adc_sequencer_control.sv
// Purpose: Control and status around an eight-channel 12-bit converter
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Analog core delivers its code on i_core_result
//
// Overview of operation
// - Eight channels, twelve-bit result
// - Result in two read-only bytes
// - Result left aligned, low nibble zero
// - Control bits 2..0 select channel
// - Control bits 5..3 configure port B
// - n gives lines 0..n-1; 7 all; 0 off
// - Analog lines drop digital and pull-high
// - Pending flag bit 6 clears at finish
// - Start rising sets pending flag
// - Start rise then fall begins conversion
// - Completion sets request; enable gates interrupt
// - Clock setting bits 1..0 pick divider
`timescale 1ns/100ps
module adc_sequencer_control
  import adc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [RESULT_BITS-1:0] i_core_result,
  output logic [2:0] o_channel_sel,
  output logic [CHANNELS-1:0] o_analog_inputs,
  output logic [CHANNELS-1:0] o_port_b_digital_en,
  output logic [CHANNELS-1:0] o_port_b_pullup_en,
  output logic o_core_power,
  output logic o_core_sample,
  output logic o_irq
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    conv_state_t fsm;
    logic [2:0] channel;
    logic [2:0] analog_cfg;
    logic conversion_pending_flag;
    logic start;
    logic [1:0] conv_clk_sel;
    logic test;
    logic [3:0] ticks;
    logic [RESULT_BITS-1:0] result;
    logic conv_irq_request_flag;
    logic conv_irq_enable;
    logic [7:0] rdata;
    logic sample;
  } ctrl_state_t;
  ctrl_state_t cur;
  ctrl_state_t next_cur;
  logic conv_tick;
  logic [RESULT_BITS-1:0] core_sync;
  logic [CHANNELS-1:0] analog_mask;
  logic wr_control;
  logic done;
  // ****************************************************************
  // Submodules
  // ****************************************************************
  conv_clk_div conv_clk_div_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(cur.fsm == ST_CONVERT),
    .i_sel(cur.conv_clk_sel),
    .o_tick(conv_tick)
  );
  sample_sync sample_sync_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_core_result),
    .o_sync(core_sync)
  );
  // ****************************************************************
  // Port B configuration decode
  // ****************************************************************
  // Thermometer mask of analog lines
  always_comb begin
    analog_mask = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (cur.analog_cfg == CFG_ALL) begin
        analog_mask[i] = 1'b1;
      end else if (i < int'(cur.analog_cfg)) begin
        analog_mask[i] = 1'b1;
      end
    end
  end
  // Pin function outputs
  assign o_analog_inputs = analog_mask;
  assign o_port_b_digital_en = ~analog_mask;
  assign o_port_b_pullup_en = ~analog_mask;
  assign o_core_power = (cur.analog_cfg != 3'h0);
  assign o_channel_sel = cur.channel;
  assign o_core_sample = cur.sample;
  assign o_rdata = cur.rdata;
  assign o_irq = cur.conv_irq_request_flag & cur.conv_irq_enable;
  assign wr_control = i_wr && (i_addr == ADDR_CONTROL);
  assign done = (cur.fsm == ST_CONVERT) && conv_tick && (cur.ticks == CONV_TICKS);
  // ****************************************************************
  // Sequencer and registers
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.sample = 1'b0;
    next_cur.rdata = 8'h00;
    // Register writes
    if (wr_control) begin
      next_cur.channel = i_wdata[CH_LSB +: 3];
      next_cur.analog_cfg = i_wdata[CFG_LSB +: 3];
      next_cur.start = i_wdata[START_BIT];
    end
    if (i_wr && (i_addr == ADDR_CLOCK_SETTING)) begin
      next_cur.conv_clk_sel = i_wdata[1:0];
      next_cur.test = i_wdata[TEST_BIT];
    end
    if (i_wr && (i_addr == ADDR_IRQ_ENABLE)) begin
      next_cur.conv_irq_enable = i_wdata[0];
    end
    if (i_wr && (i_addr == ADDR_IRQ_CLEAR) && i_wdata[0]) begin
      next_cur.conv_irq_request_flag = 1'b0;
    end
    // Start edges drive the sequencer
    case (cur.fsm)
      ST_IDLE: begin
        if (wr_control && !cur.start && i_wdata[START_BIT]) begin
          next_cur.conversion_pending_flag = 1'b1;
          next_cur.fsm = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (wr_control && !i_wdata[START_BIT]) begin
          next_cur.fsm = ST_CONVERT;
          next_cur.ticks = 4'h0;
          next_cur.sample = 1'b1;
        end
      end
      ST_CONVERT: begin
        // A new rising start aborts and re-arms the converter
        if (wr_control && !cur.start && i_wdata[START_BIT]) begin
          next_cur.conversion_pending_flag = 1'b1;
          next_cur.fsm = ST_ARMED;
        end else if (done) begin
          next_cur.result = core_sync;
          next_cur.conversion_pending_flag = 1'b0;
          next_cur.conv_irq_request_flag = 1'b1;
          next_cur.fsm = ST_IDLE;
        end else if (conv_tick) begin
          next_cur.ticks = cur.ticks + 4'h1;
        end
      end
      default: begin
        next_cur.fsm = ST_IDLE;
      end
    endcase
    // Register reads
    if (i_rd) begin
      case (i_addr)
        ADDR_RESULT_LOW: next_cur.rdata = {cur.result[3:0], 4'h0};
        ADDR_RESULT_HIGH: next_cur.rdata = cur.result[11:4];
        ADDR_CONTROL: next_cur.rdata = {cur.start, cur.conversion_pending_flag,
                                        cur.analog_cfg, cur.channel};
        ADDR_CLOCK_SETTING: next_cur.rdata = {cur.test, 5'h00, cur.conv_clk_sel};
        ADDR_IRQ_STATUS: next_cur.rdata = {7'h00, cur.conv_irq_request_flag};
        ADDR_IRQ_ENABLE: next_cur.rdata = {7'h00, cur.conv_irq_enable};
        default: next_cur.rdata = 8'h00;
      endcase
    end
  end
  // Register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
      cur.conversion_pending_flag <= CONTROL_RESET[PEND_BIT];
    end else begin
      cur <= next_cur;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_SET_ON_RISE: assert property (wr_control && !cur.start && i_wdata[START_BIT]
    |=> cur.conversion_pending_flag) else $error("pending flag not set");
  AST_START_CONV: assert property ((cur.fsm == ST_ARMED) && wr_control && !i_wdata[START_BIT]
    |=> (cur.fsm == ST_CONVERT) && cur.sample) else $error("conversion not begun");
  AST_DONE_CLEAR: assert property (done |=> !cur.conversion_pending_flag && cur.conv_irq_request_flag)
    else $error("finish effects missing");
  AST_RESULT_LOAD: assert property (done |=> cur.result == $past(core_sync))
    else $error("result not loaded");
  AST_IRQ_GATE: assert property (o_irq == (cur.conv_irq_request_flag && cur.conv_irq_enable))
    else $error("interrupt gating wrong");
  AST_READ_LOW: assert property (i_rd && i_addr == ADDR_RESULT_LOW
    |=> o_rdata == {$past(cur.result[3:0]), 4'h0}) else $error("low byte wrong");
  AST_READ_HIGH: assert property (i_rd && i_addr == ADDR_RESULT_HIGH
    |=> o_rdata == $past(cur.result[11:4])) else $error("high byte wrong");
  AST_CLK_ZERO: assert property (i_rd && i_addr == ADDR_CLOCK_SETTING
    |=> o_rdata[6:2] == 5'h00) else $error("unused bits not zero");
  AST_ANALOG_MAP: assert property (o_port_b_digital_en == ~o_analog_inputs
    && o_core_power == (cur.analog_cfg != 3'h0)) else $error("port b map wrong");
  AST_CHANNEL: assert property (wr_control |=> o_channel_sel == $past(i_wdata[2:0]))
    else $error("channel not taken");

  // ****************************************************************
  // Conversion length helper
  // ****************************************************************
  // Cycles spent in the running conversion, cleared outside it
  logic [9:0] conv_cycles;
  logic sel_moved;
  logic [9:0] conv_span;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_cycles <= 10'h000;
      sel_moved <= 1'b0;
    end else if (cur.fsm != ST_CONVERT) begin
      conv_cycles <= 10'h000;
      sel_moved <= 1'b0;
    end else begin
      conv_cycles <= conv_cycles + 10'h001;
      // A divider change mid-conversion voids the length check
      if (i_wr && (i_addr == ADDR_CLOCK_SETTING)) begin
        sel_moved <= 1'b1;
      end
    end
  end

  // Expected length: fourteen converter clocks of the chosen divider
  always_comb begin
    case (cur.conv_clk_sel)
      CLK_SEL_DIV2: conv_span = (10'(DIV2_LAST) + 10'h001) * (10'(CONV_TICKS) + 10'h001);
      CLK_SEL_DIV8: conv_span = (10'(DIV8_LAST) + 10'h001) * (10'(CONV_TICKS) + 10'h001);
      default: conv_span = (10'(DIV32_LAST) + 10'h001) * (10'(CONV_TICKS) + 10'h001);
    endcase
  end

  // ****************************************************************
  // Further assertions
  // ****************************************************************
  // Fixed conversion length per divider
  AST_CONV_LENGTH: assert property (done && !sel_moved |-> conv_cycles == conv_span)
    else $error("conversion length wrong");

  // Partial configurations give a thermometer of low lines
  AST_MASK_THERMO: assert property ((cur.analog_cfg != CFG_ALL)
    |-> o_analog_inputs == 8'((9'h001 << cur.analog_cfg) - 9'h001)) else $error("analog mask wrong");

  // Top configuration makes every line analog
  AST_MASK_ALL: assert property ((cur.analog_cfg == CFG_ALL) |-> o_analog_inputs == 8'hff)
    else $error("all-analog mask wrong");

  // Configuration zero keeps lines digital and the core off
  AST_POWER_OFF: assert property ((cur.analog_cfg == 3'h0)
    |-> !o_core_power && (o_analog_inputs == 8'h00)) else $error("core not powered off");

  // Pull-high follows the digital function
  AST_PULLUP_OFF: assert property (o_port_b_pullup_en == ~o_analog_inputs)
    else $error("pull-high not dropped");

  // Sample strobe is a single cycle
  AST_SAMPLE_ONE: assert property (o_core_sample |=> !o_core_sample)
    else $error("sample strobe too long");

  // Pending flag stays set while armed
  AST_ARMED_PEND: assert property ((cur.fsm == ST_ARMED) |-> cur.conversion_pending_flag)
    else $error("pending lost while armed");

  // Pending flag stays set while converting
  AST_CONVERT_PEND: assert property ((cur.fsm == ST_CONVERT) |-> cur.conversion_pending_flag)
    else $error("pending lost while converting");

  // A fresh start edge mid-conversion re-arms
  AST_RESTART: assert property ((cur.fsm == ST_CONVERT) && wr_control && !cur.start
    && i_wdata[START_BIT] |=> (cur.fsm == ST_ARMED)) else $error("restart not armed");

  // Tick counter never passes its last value
  AST_TICKS_BOUND: assert property ((cur.fsm == ST_CONVERT) |-> cur.ticks <= CONV_TICKS)
    else $error("tick count overrun");

  // Divider stays quiet outside a conversion
  AST_IDLE_NO_TICK: assert property ((cur.fsm != ST_CONVERT) |=> !conv_tick)
    else $error("divider ticks while idle");

  // Divide by two gives a tick every second cycle
  AST_DIV2_RATE: assert property (conv_tick && (cur.conv_clk_sel == CLK_SEL_DIV2)
    && (cur.fsm == ST_CONVERT) && !done ##1 (cur.fsm == ST_CONVERT)
    && (cur.conv_clk_sel == CLK_SEL_DIV2) |=> conv_tick) else $error("divide by two rate wrong");

  // Divider select reads back
  AST_CLK_SEL_READ: assert property (i_rd && i_addr == ADDR_CLOCK_SETTING
    |=> o_rdata[1:0] == $past(cur.conv_clk_sel)) else $error("divider select not read back");

  // Pending flag reads back in bit six
  AST_CTRL_READ: assert property (i_rd && i_addr == ADDR_CONTROL
    |=> o_rdata[PEND_BIT] == $past(cur.conversion_pending_flag)) else $error("pending not read back");

  // Clear write drops the request unless a finish lands with it
  AST_IRQ_CLEAR: assert property (i_wr && (i_addr == ADDR_IRQ_CLEAR) && i_wdata[0] && !done
    |=> !cur.conv_irq_request_flag) else $error("request not cleared");

  // A finish beside a clear keeps the request
  AST_SET_WINS: assert property (done && !(wr_control && !cur.start && i_wdata[START_BIT])
    |=> cur.conv_irq_request_flag) else $error("finish lost to clear");

  // Read data is zero outside the answer cycle
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");

  // Cover the main scenarios
  COV_CONVERSION: cover property (cur.fsm == ST_CONVERT ##1 done);
  COV_IRQ: cover property (o_irq);
  COV_ALL_ANALOG: cover property (cur.analog_cfg == CFG_ALL);
  COV_RESTART: cover property ((cur.fsm == ST_CONVERT) && wr_control && i_wdata[START_BIT]);
endmodule : adc_sequencer_control

// File: sim/adc_sequencer_control_tb.sv
// Purpose: Self-checking bench for the converter sequencer control block
// Assumes: 20 MHz clock; register port with read data one cycle after the strobe
// Notes: The bench drives the analog core result itself
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module adc_sequencer_control_tb import adc_ctrl_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [RESULT_BITS-1:0] i_core_result = 12'h000;
  logic [7:0] o_rdata;
  logic [2:0] o_channel_sel;
  logic [CHANNELS-1:0] o_analog_inputs;
  logic [CHANNELS-1:0] o_port_b_digital_en;
  logic [CHANNELS-1:0] o_port_b_pullup_en;
  logic o_core_power;
  logic o_core_sample;
  logic o_irq;
  int n_fail = 0;
  int n_tests = 0;

  // ****************************************
  // Clock and design
  // ****************************************
  always #25 i_clk = ~i_clk;

  adc_sequencer_control adc_sequencer_control_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_result(i_core_result),
    .o_channel_sel(o_channel_sel), .o_analog_inputs(o_analog_inputs),
    .o_port_b_digital_en(o_port_b_digital_en), .o_port_b_pullup_en(o_port_b_pullup_en),
    .o_core_power(o_core_power), .o_core_sample(o_core_sample), .o_irq(o_irq));

  // ****************************************
  // Bus cycles and closing
  // ****************************************
  task automatic test_done;
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset held eight cycles, then reset values checked
  task automatic reset_check;
    logic [7:0] d;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ADDR_CONTROL, d);
    `CHK("control_reset", 8'h40, d)
    rd(ADDR_CLOCK_SETTING, d);
    `CHK("clock_reset", 8'h00, d)
    rd(ADDR_IRQ_STATUS, d);
    `CHK("status_reset", 8'h00, d)
    `CHK("irq_reset", 1'b0, o_irq)
    `CHK("power_reset", 1'b0, o_core_power)
    `CHK("digital_reset", 8'hff, o_port_b_digital_en)
  endtask : reset_check

  // Every port configuration and channel value
  task automatic cfg_sweep;
    logic [7:0] m;
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_CONTROL, {2'b00, 3'(n), 3'(7 - n)});
      m = (n == 7) ? 8'hff : 8'((1 << n) - 1);
      `CHK("analog_mask", m, o_analog_inputs)
      `CHK("digital_en", ~m, o_port_b_digital_en)
      `CHK("pullup_en", ~m, o_port_b_pullup_en)
      `CHK("power", (n != 0), o_core_power)
      `CHK("channel", 3'(7 - n), o_channel_sel)
    end
  endtask : cfg_sweep

  // Unused clock setting bits, read-only result, unmapped place
  task automatic reg_access;
    logic [7:0] d;
    wr(ADDR_CLOCK_SETTING, 8'h7f);
    rd(ADDR_CLOCK_SETTING, d);
    `CHK("clock_unused", 8'h03, d)
    wr(ADDR_RESULT_LOW, 8'hff);
    rd(ADDR_RESULT_LOW, d);
    `CHK("low_readonly", 8'hf0, d)
    rd(8'h30, d);
    `CHK("unmapped", 8'h00, d)
  endtask : reg_access

  // Full conversion at one divider, with or without interrupt enable
  task automatic conv(input logic [1:0] sel, input logic [11:0] res, input logic en, input int div);
    logic [7:0] d;
    int t;
    i_core_result <= res;
    wr(ADDR_CLOCK_SETTING, {6'h00, sel});
    wr(ADDR_IRQ_ENABLE, {7'h00, en});
    wr(ADDR_CONTROL, 8'h0b);
    wr(ADDR_CONTROL, 8'h8b);
    rd(ADDR_CONTROL, d);
    `CHK("pending_set", 1'b1, d[PEND_BIT])
    wr(ADDR_CONTROL, 8'h0b);
    t = 0;
    while (o_core_sample !== 1'b1 && t < 10) begin
      @(posedge i_clk);
      #1;
      t++;
    end
    `CHK("sample_seen", 1'b1, o_core_sample)
    @(posedge i_clk);
    #1;
    `CHK("sample_one", 1'b0, o_core_sample)
    t = 1;
    do begin
      rd(ADDR_CONTROL, d);
      t += 2;
    end while (d[PEND_BIT] !== 1'b0 && t < 2000);
    if (t >= 2000) begin
      n_fail++;
      test_done();
    end
    `CHK("conv_length", 1'b1, (t >= 13 * div && t <= 14 * div + 8))
    rd(ADDR_RESULT_HIGH, d);
    `CHK("result_high", res[11:4], d)
    rd(ADDR_RESULT_LOW, d);
    `CHK("result_low", {res[3:0], 4'h0}, d)
    rd(ADDR_IRQ_STATUS, d);
    `CHK("request_set", 1'b1, d[0])
    `CHK("irq_gated", en, o_irq)
    wr(ADDR_IRQ_ENABLE, 8'h01);
    `CHK("irq_enabled", 1'b1, o_irq)
    wr(ADDR_IRQ_CLEAR, 8'h01);
    `CHK("irq_cleared", 1'b0, o_irq)
    rd(ADDR_IRQ_STATUS, d);
    `CHK("request_clear", 1'b0, d[0])
  endtask : conv

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_check();
    cfg_sweep();
    conv(CLK_SEL_DIV2, 12'habc, 1'b0, 2);
    conv(CLK_SEL_DIV8, 12'h5a3, 1'b1, 8);
    conv(CLK_SEL_DIV32, 12'hf0f, 1'b1, 32);
    reg_access();
    reset_check();
    test_done();
  end
endmodule : adc_sequencer_control_tb
